/* File: srl_slave.sv */
// Purpose: serial register slave: loopback and multi-register write
// Assumes: byte stream from a uart, end of frame marked by frame_end_in
// Notes:   replies leave through a 4-byte buffer; sender may stall it
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - a loopback request is echoed byte for byte, crc included.
// - word k of a write lands in register start plus k.
// - each register word travels high byte first, then low byte.
// - reference registers are readable and writable command inputs.
// - run bit 0 requests run, bit 1 selects reverse rotation.
// - run bits 6 to 10 drive multi-function inputs 3 to 7.
// - run bits 11 to 15 have no effect.
// - the speed reference holds the frequency in selectable units.
// - analog levels are signed from -726 to 726, 660 meaning 10 V.
// - the crc starts at all ones and covers every byte before it.
// - each crc bit step shifts right, xoring a001 when a one drops.
`timescale 1ns/10ps
module srl_slave
  import srl_pkg::*;
#(
  parameter logic [7:0] SLAVE_ADDR = 8'h01
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  input  wire logic        frame_end_in,
  input  wire logic [2:0]  frequency_unit_parameter_in,
  input  wire logic [15:0] rd_addr_in,
  output logic      [15:0] rd_data_out,
  output logic      [7:0]  tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic             run_request_out,
  output logic             reverse_out,
  output logic      [4:0]  mf_input_out,
  output logic      [15:0] speed_reference_out,
  output logic      [2:0]  speed_unit_out,
  output logic      [15:0] loop_target_out,
  output logic      [15:0] analog_one_out,
  output logic      [15:0] analog_two_out
);
  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RX    = 2'b00,
    ST_CHECK = 2'b01,
    ST_TX    = 2'b11
  } srl_state_t;

  srl_state_t  state_r;
  logic [7:0]  buf_r [FRAME_BYTES];
  logic [5:0]  len_r;
  logic [5:0]  idx_r;
  logic [5:0]  tx_len_r;
  logic [15:0] crc_r;
  logic [15:0] crc_at_r;
  logic [15:0] rx_crc_prev_r;
  logic [15:0] run_r;
  logic [15:0] speed_r;
  logic [15:0] target_r;
  logic [15:0] ana1_r;
  logic [15:0] ana2_r;
  logic [15:0] tx_crc_r;
  logic [7:0]  err_r;
  logic        err_mode_r;
  logic [4:0]  wk_r;

  // ------------------------------------------------------------
  // crc: one byte per call, right shifting
  // ------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  //------------------------------------------------------------
  // frame decode
  //------------------------------------------------------------
  wire [7:0]  fn_w      = buf_r[1];
  wire [15:0] start_w   = {buf_r[2], buf_r[3]};
  wire [15:0] qty_w     = {buf_r[4], buf_r[5]};
  wire [7:0]  nbytes_w  = buf_r[6];
  // the crc register has also eaten the two check bytes; compare the
  // value taken just before them, stored with the low byte first
  wire [15:0] rx_crc_w  = {buf_r[len_r-6'd1], buf_r[len_r-6'd2]};
  wire        crc_ok_w  = (len_r >= 6'd4) && (rx_crc_w == crc_at_r);
  wire        mine_w    = (buf_r[0] == SLAVE_ADDR);
  wire [15:0] last_w    = start_w + qty_w - 16'h0001;
  wire        qty_ok_w  = (qty_w != 16'h0000) &&
                          (qty_w <= 16'(MAX_WRITE_REGS));
  wire        len_ok_w  = (nbytes_w == {qty_w[6:0], 1'b0}) &&
                          (len_r == 6'(9) + nbytes_w[5:0]);
  // reserved word 0 and holes 3..5 are refused rather than stored
  wire        range_ok_w = (start_w >= REG_RUN_INPUT_COMMANDS) &&
                           (last_w <= REG_ANALOG_OUT_TWO_LEVEL) &&
                           !((start_w <= 16'h0005) &&
                             (last_w >= 16'h0003));
  wire        is_loop_w  = (fn_w == FN_LOOPBACK) && (len_r == 6'd8);
  wire        is_wr_w    = (fn_w == FN_WRITE_MULTI);
  wire [7:0]  err_code_w = !is_wr_w && !is_loop_w ? ERR_BAD_FUNCTION :
                           !range_ok_w ? ERR_BAD_ADDRESS :
                           ERR_BAD_VALUE;
  wire        wr_good_w  = is_wr_w && qty_ok_w && len_ok_w && range_ok_w;

  // write stream: word k sits at bytes 7+2k (high) and 8+2k (low)
  wire [5:0]  wb_w     = 6'd7 + {wk_r, 1'b0};
  wire [15:0] wword_w  = {buf_r[wb_w], buf_r[wb_w + 6'd1]};
  wire [15:0] waddr_w  = start_w + {11'h000, wk_r};
  wire        writing_w = (state_r == ST_CHECK) && wr_good_w &&
                          mine_w && crc_ok_w &&
                          (wk_r < qty_w[4:0]);

  //------------------------------------------------------------
  // reply bytes
  //------------------------------------------------------------
  wire        fifo_rdy_w;
  wire        tx_push_w = (state_r == ST_TX);
  logic [7:0] tx_byte_w;
  always_comb begin
    tx_byte_w = buf_r[idx_r];
    if (err_mode_r) begin
      unique case (idx_r)
        6'd0:    tx_byte_w = SLAVE_ADDR;
        6'd1:    tx_byte_w = fn_w | FN_ERR_FLAG;
        6'd2:    tx_byte_w = err_r;
        6'd3:    tx_byte_w = tx_crc_r[7:0];
        default: tx_byte_w = tx_crc_r[15:8];
      endcase
    end else if (is_wr_w) begin
      if (idx_r == 6'd6) tx_byte_w = tx_crc_r[7:0];
      else if (idx_r == 6'd7) tx_byte_w = tx_crc_r[15:8];
    end
  end

  // reply crc for error and write answers, computed once at check
  wire [15:0] ec_w = crc_byte(crc_byte(crc_byte(CRC_INIT, SLAVE_ADDR),
                     fn_w | FN_ERR_FLAG), err_code_w);
  wire [15:0] wc_w = crc_byte(crc_byte(crc_byte(crc_byte(crc_byte(
                     crc_byte(CRC_INIT, buf_r[0]), buf_r[1]), buf_r[2]),
                     buf_r[3]), buf_r[4]), buf_r[5]);

  //------------------------------------------------------------
  // sequencer
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (state_r == ST_RX && rx_valid_in && len_r < 6'(FRAME_BYTES))
      buf_r[len_r] <= rx_data_in;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r       <= ST_RX;
      len_r         <= '0;
      idx_r         <= '0;
      tx_len_r      <= '0;
      crc_r         <= CRC_INIT;
      crc_at_r      <= CRC_INIT;
      rx_crc_prev_r <= CRC_INIT;
      tx_crc_r      <= 16'h0000;
      err_r         <= 8'h00;
      err_mode_r    <= 1'b0;
      wk_r          <= '0;
    end else begin
      unique case (state_r)
        ST_RX: begin
          if (rx_valid_in && len_r < 6'(FRAME_BYTES)) begin
            len_r         <= len_r + 6'd1;
            crc_r         <= crc_byte(crc_r, rx_data_in);
            rx_crc_prev_r <= crc_r;
            crc_at_r      <= rx_crc_prev_r;
          end
          if (frame_end_in) begin
            state_r <= ST_CHECK;
            wk_r    <= '0;
          end
        end
        ST_CHECK: begin
          if (writing_w) begin
            wk_r <= wk_r + 5'd1;
          end else begin
            idx_r      <= '0;
            err_r      <= err_code_w;
            err_mode_r <= !(is_loop_w || wr_good_w);
            tx_crc_r   <= (is_loop_w || wr_good_w) ? wc_w : ec_w;
            tx_len_r   <= is_loop_w ? 6'd8 :
                          wr_good_w ? 6'd8 : 6'd5;
            // foreign address, bad crc: stay silent
            state_r    <= (mine_w && crc_ok_w) ? ST_TX : ST_RX;
            if (!(mine_w && crc_ok_w)) begin
              len_r <= '0;
              crc_r <= CRC_INIT;
            end
          end
        end
        ST_TX: begin
          if (fifo_rdy_w) begin
            idx_r <= idx_r + 6'd1;
            if (idx_r == tx_len_r - 6'd1) begin
              state_r <= ST_RX;
              len_r   <= '0;
              crc_r   <= CRC_INIT;
            end
          end
        end
        default: state_r <= ST_RX;
      endcase
    end
  end

  //------------------------------------------------------------
  // reference registers
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_r    <= REG_RESET_VAL;
      speed_r  <= REG_RESET_VAL;
      target_r <= REG_RESET_VAL;
      ana1_r   <= REG_RESET_VAL;
      ana2_r   <= REG_RESET_VAL;
    end else if (writing_w) begin
      if (waddr_w == REG_RUN_INPUT_COMMANDS) run_r <= wword_w;
      if (waddr_w == REG_SPEED_REFERENCE) speed_r <= wword_w;
      if (waddr_w == REG_LOOP_TARGET_VALUE) target_r <= wword_w;
      // out of range levels are clamped to the analog span
      if (waddr_w == REG_ANALOG_OUT_ONE_LEVEL) ana1_r <= clamp(wword_w);
      if (waddr_w == REG_ANALOG_OUT_TWO_LEVEL) ana2_r <= clamp(wword_w);
    end
  end

  function automatic logic [15:0] clamp(input logic [15:0] v);
    if ($signed(v) > ANALOG_MAX) return ANALOG_MAX;
    if ($signed(v) < ANALOG_MIN) return ANALOG_MIN;
    return v;
  endfunction

  // reads: word view of the reference map
  assign rd_data_out =
    (rd_addr_in == REG_RUN_INPUT_COMMANDS)   ? run_r :
    (rd_addr_in == REG_SPEED_REFERENCE)      ? speed_r :
    (rd_addr_in == REG_LOOP_TARGET_VALUE)    ? target_r :
    (rd_addr_in == REG_ANALOG_OUT_ONE_LEVEL) ? ana1_r :
    (rd_addr_in == REG_ANALOG_OUT_TWO_LEVEL) ? ana2_r : 16'h0000;

  assign run_request_out     = run_r[RUN_BIT_RUN];
  assign reverse_out         = run_r[RUN_BIT_REV];
  // bits 11..15 are stored but drive nothing
  assign mf_input_out        = run_r[RUN_BIT_MF_HI:RUN_BIT_MF_LO];
  assign speed_reference_out = speed_r;
  assign speed_unit_out      = frequency_unit_parameter_in;
  assign loop_target_out     = target_r;
  assign analog_one_out      = ana1_r;
  assign analog_two_out      = ana2_r;

  //------------------------------------------------------------
  // reply buffer
  //------------------------------------------------------------
  srl_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .rstn_in      (rstn_in),
    .wr_data_in   (tx_byte_w),
    .wr_valid_in  (tx_push_w),
    .wr_ready_out (fifo_rdy_w),
    .rd_data_out  (tx_data_out),
    .rd_valid_out (tx_valid_out),
    .rd_ready_in  (tx_ready_in)
  );

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  a_run_bits_map: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    1'b1 |-> run_request_out == run_r[0] && reverse_out == run_r[1])
    else $error("run bits misrouted");
  a_analog_span: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    $signed(ana1_r) <= 726 && $signed(ana1_r) >= -726)
    else $error("analog level out of span");
  a_write_lands: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    writing_w && waddr_w == REG_SPEED_REFERENCE |=> speed_r == $past(wword_w))
    else $error("write word not stored");
  a_err_fn_flag: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    tx_push_w && err_mode_r && idx_r == 6'd1 |-> tx_byte_w[7])
    else $error("error reply lacks flag");
  a_analog_two_span: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    $signed(ana2_r) <= 726 && $signed(ana2_r) >= -726)
    else $error("second analog level out of span");
  a_loop_echo: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    tx_push_w && !err_mode_r && is_loop_w |-> tx_byte_w == buf_r[idx_r])
    else $error("loopback byte altered");
  a_wr_reply_ok: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    state_r == ST_CHECK && !writing_w && wr_good_w |=>
      !err_mode_r && tx_len_r == 6'd8)
    else $error("write answer not normal");
  a_err_reply_len: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    state_r == ST_CHECK && !writing_w && !(is_loop_w || wr_good_w) |=>
      err_mode_r && tx_len_r == 6'd5)
    else $error("error answer malformed");
  a_silent_drop: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    state_r == ST_CHECK && !writing_w && !crc_ok_w |=> state_r == ST_RX)
    else $error("bad check word answered");
  a_run_lands: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    writing_w && waddr_w == REG_RUN_INPUT_COMMANDS |=>
      run_r == $past(wword_w))
    else $error("run word not stored");
  a_level_kept: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    writing_w && waddr_w == REG_ANALOG_OUT_ONE_LEVEL &&
      $signed(wword_w) <= 726 && $signed(wword_w) >= -726 |=>
      ana1_r == $past(wword_w))
    else $error("in span level altered");
  a_reply_holds: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply byte dropped while stalled");
  a_word_steps: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    writing_w |=> wk_r == $past(wk_r) + 5'd1)
    else $error("write word index skipped");
endmodule

/* File: srl_pkg.sv */
// Purpose: constants for the serial register slave
// Assumes: one clock, byte stream in and out
// Notes:   register numbers are word indices on the serial protocol
package srl_pkg;
  localparam logic [15:0] REG_RESERVED_ZERO = 16'h0000;
  localparam logic [15:0] REG_RUN_INPUT_COMMANDS = 16'h0001;
  localparam logic [15:0] REG_SPEED_REFERENCE = 16'h0002;
  localparam logic [15:0] REG_LOOP_TARGET_VALUE = 16'h0006;
  localparam logic [15:0] REG_ANALOG_OUT_ONE_LEVEL = 16'h0007;
  localparam logic [15:0] REG_ANALOG_OUT_TWO_LEVEL = 16'h0008;
  localparam logic [15:0] REG_RESET_VAL = 16'h0000;
  localparam logic [7:0]  FN_LOOPBACK = 8'h08;
  localparam logic [7:0]  FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0]  FN_ERR_FLAG = 8'h80;
  localparam logic [7:0]  ERR_BAD_FUNCTION = 8'h01;
  localparam logic [7:0]  ERR_BAD_ADDRESS = 8'h02;
  localparam logic [7:0]  ERR_BAD_VALUE = 8'h03;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int          RUN_BIT_RUN = 0;
  localparam int          RUN_BIT_REV = 1;
  localparam int          RUN_BIT_MF_LO = 6;
  localparam int          RUN_BIT_MF_HI = 10;
  localparam logic signed [15:0] ANALOG_MAX = 16'sh02D6;
  localparam logic signed [15:0] ANALOG_MIN = -16'sh02D6;
  localparam int          MAX_WRITE_REGS = 16;
  localparam int          FRAME_BYTES = 40;
  localparam int          GAP_US = 4;
  localparam int          CLK_MHZ = 25;
  localparam int          GAP_CYCLES = GAP_US * CLK_MHZ;
endpackage

/* File: srl_fifo.sv */
// Purpose: small ready/valid byte buffer on the reply path
// Assumes: same clock on both sides
// Notes:   full and empty are exact
`timescale 1ns/10ps
module srl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire do_wr = wr_valid_in && wr_ready_out;
  wire do_rd = rd_valid_out && rd_ready_in;
  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_r != '0);
  assign rd_data_out  = mem_r[rp_r];
  always_ff @(posedge sys_clk_in) begin
    if (do_wr) mem_r[wp_r] <= wr_data_in;
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (do_rd) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

/* File: srl_host.sv */
// Purpose: host master model: sends request frames, collects replies
// Assumes: shares the slave's clock; bytes arrive back to back
// Notes:   with stall set, tx_ready is high one cycle in three
`timescale 1ns/10ps
module srl_host (
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out,
  output logic            frame_end_out,
  output logic            tx_ready_out
);
  logic [7:0] rsp [$];
  bit         stall;
  int         ph;
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    frame_end_out = 1'b0;
    tx_ready_out = 1'b1;
    stall = 1'b0;
    ph = 0;
  end
  //------------------------------------------------------------
  // frame check word
  //------------------------------------------------------------
  function automatic logic [15:0] crc(input logic [7:0] b [0:39],
                                      input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction
  //------------------------------------------------------------
  // request side
  //------------------------------------------------------------
  // fields are given high byte first, so words go out high first
  task automatic send(input logic [127:0] v, input int n, input bit bad);
    logic [7:0]  b [0:39];
    logic [15:0] c;
    for (int i = 0; i < n; i++) begin
      b[i] = v[8*(n-1-i) +: 8];
    end
    c = crc(b, n) ^ {15'h0000, bad};
    b[n] = c[7:0];
    b[n+1] = c[15:8];
    rsp.delete();
    for (int i = 0; i < n + 2; i++) begin
      @(posedge sys_clk_in);
      #1;
      rx_data_out = b[i];
      rx_valid_out = 1'b1;
    end
    @(posedge sys_clk_in);
    #1;
    // released line shows the inverse, not a stale byte
    rx_data_out = ~b[n+1];
    rx_valid_out = 1'b0;
    frame_end_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    frame_end_out = 1'b0;
  endtask
  //------------------------------------------------------------
  // reply side
  //------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      rsp.push_back(tx_data_in);
    end
    ph <= ph + 1;
    tx_ready_out <= #1 !stall || (ph % 3 == 0);
  end
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the serial register slave
// Assumes: host model in srl_host, one clock
// Notes:   replies are awaited in full before the next request
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %0t got %h want %h", $time, g, e); \
  end end
module tb;
  logic        clk;
  logic        rstn;
  logic [7:0]  rxd;
  logic        rxv;
  logic        fend;
  logic [2:0]  unit;
  logic [15:0] rd_addr;
  logic [15:0] rd_data;
  logic [7:0]  txd;
  logic        txv;
  logic        txr;
  logic        run;
  logic        rev;
  logic [4:0]  mf;
  logic [15:0] spd;
  logic [2:0]  spd_unit;
  logic [15:0] tgt;
  logic [15:0] an1;
  logic [15:0] an2;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  srl_slave DUT (.sys_clk_in(clk), .rstn_in(rstn), .rx_data_in(rxd),
    .rx_valid_in(rxv), .frame_end_in(fend),
    .frequency_unit_parameter_in(unit), .rd_addr_in(rd_addr),
    .rd_data_out(rd_data), .tx_data_out(txd), .tx_valid_out(txv),
    .tx_ready_in(txr), .run_request_out(run), .reverse_out(rev),
    .mf_input_out(mf), .speed_reference_out(spd),
    .speed_unit_out(spd_unit), .loop_target_out(tgt),
    .analog_one_out(an1), .analog_two_out(an2));
  srl_host P (.sys_clk_in(clk), .tx_data_in(txd), .tx_valid_in(txv),
    .rx_data_out(rxd), .rx_valid_out(rxv), .frame_end_out(fend),
    .tx_ready_out(txr));
  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // generous ceiling: whole run needs under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rd_addr = a;
    #1;
    `CHK(rd_data, e)
  endtask
  // n = 0 means no reply may come at all
  task automatic expect_rsp(input logic [127:0] v, input int n);
    logic [7:0]  b [0:39];
    logic [15:0] c;
    int          w;
    for (int i = 0; i < n; i++) begin
      b[i] = v[8*(n-1-i) +: 8];
    end
    c = P.crc(b, n);
    b[n] = c[7:0];
    b[n+1] = c[15:8];
    w = 0;
    while (n > 0 && P.rsp.size() < n + 2 && w < 600) begin
      @(posedge clk);
      w++;
    end
    repeat (60) @(posedge clk);
    `CHK(P.rsp.size(), (n > 0) ? n + 2 : 0)
    for (int i = 0; i < n + 2 && i < P.rsp.size(); i++) begin
      `CHK(P.rsp[i], b[i])
    end
  endtask
  task automatic ws(input logic [15:0] r, input logic [15:0] v);
    P.send({8'h01, 8'h10, r, 16'h0001, 8'h02, v}, 9, 1'b0);
    expect_rsp({8'h01, 8'h10, r, 16'h0001}, 6);
  endtask
  //------------------------------------------------------------
  // tests
  //------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    unit = 3'h0;
    rd_addr = 16'h0000;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    rd(16'h0001, 16'h0000);
    rd(16'h0008, 16'h0000);
    `CHK(txv, 1'b0)
    P.send(48'h01080000A537, 6, 1'b0);
    expect_rsp(48'h01080000A537, 6);
    `CHK(P.rsp[6], 8'hDA)
    `CHK(P.rsp[7], 8'h8D)
    P.send(48'h0108FFFF1234, 6, 1'b0);
    expect_rsp(48'h0108FFFF1234, 6);
    P.stall = 1'b1;
    P.send(88'h0110000100020400010258, 11, 1'b0);
    expect_rsp(48'h011000010002, 6);
    `CHK(P.rsp[7], 8'h08)
    rd(16'h0002, 16'h0258);
    `CHK(run, 1'b1)
    `CHK(rev, 1'b0)
    `CHK(spd, 16'h0258)
    ws(16'h0001, 16'hFFC2);
    `CHK({run, rev, mf}, 7'h3F)
    rd(16'h0001, 16'hFFC2);
    for (int k = 0; k < 5; k++) begin
      ws(16'h0001, 16'h0040 << k);
      `CHK(mf, 5'h01 << k)
    end
    P.send(104'h01100006000306123402D6FD2A, 13, 1'b0);
    expect_rsp(48'h011000060003, 6);
    `CHK(tgt, 16'h1234)
    `CHK(an1, 16'h02D6)
    `CHK(an2, 16'hFD2A)
    ws(16'h0007, 16'h0294);
    `CHK(an1, 16'h0294)
    P.stall = 1'b0;
    P.send(72'h0110000700010202D7, 9, 1'b0);
    expect_rsp(48'h011000070001, 6);
    `CHK(an1, 16'h02D6)
    P.send(48'h010300000001, 6, 1'b0);
    expect_rsp(24'h018301, 3);
    P.send(72'h011000000001020000, 9, 1'b0);
    expect_rsp(24'h019002, 3);
    P.send(88'h0110000100020300000000, 11, 1'b0);
    expect_rsp(24'h019003, 3);
    rd(16'h0001, 16'h0040 << 4);
    P.send(48'h01080000A537, 6, 1'b1);
    expect_rsp(48'h0, 0);
    P.send(72'h01100002000102FFFF, 9, 1'b1);
    expect_rsp(48'h0, 0);
    `CHK(spd, 16'h0258)
    P.send(48'h02080000A537, 6, 1'b0);
    expect_rsp(48'h0, 0);
    for (int u = 0; u < 8; u++) begin
      unit = u[2:0];
      #1;
      `CHK(spd_unit, u[2:0])
    end
    stop_test();
  end
endmodule
